// file: core/sdi_pkg.sv
/*
  Shared constants for the quad-bank synchronous DRAM start-up and addressing core:
  command codes, start-up phases, organizations, register map and timing counts.
  Assumes a single 100 MHz clock domain shared by the core and its memory controller.
*/
package sdi_pkg;

  localparam int CLK_MHZ = 100;

  // start-up idle time and the waits after precharge, refresh and mode load
  localparam int STARTUP_WAIT_US = 100;
  localparam int STARTUP_WAIT_CYC = STARTUP_WAIT_US * CLK_MHZ;
  localparam int PRECHARGE_PERIOD_NS = 20;
  localparam int REFRESH_CYCLE_PERIOD_NS = 70;
  localparam int MODE_LOAD_WAIT_NS = 20;
  // least times round up to whole cycles
  localparam int PRECHARGE_PERIOD_CYC = (PRECHARGE_PERIOD_NS * CLK_MHZ + 999) / 1000;
  localparam int REFRESH_CYCLE_PERIOD_CYC = (REFRESH_CYCLE_PERIOD_NS * CLK_MHZ + 999) / 1000;
  localparam int MODE_LOAD_WAIT_CYC = (MODE_LOAD_WAIT_NS * CLK_MHZ + 999) / 1000;

  localparam int ROW_W = 13;
  localparam int COL_W = 11;
  localparam int MIN_REFRESHES = 2;

  // command code {chip select, row strobe, column strobe, write enable}, all active low
  typedef enum logic [3:0] {
    SDI_CMD_MLOAD = 4'b0000,
    SDI_CMD_AREF = 4'b0001,
    SDI_CMD_PRE  = 4'b0010,
    SDI_CMD_ACT  = 4'b0011,
    SDI_CMD_WR   = 4'b0100,
    SDI_CMD_RD   = 4'b0101,
    SDI_CMD_BST  = 4'b0110,
    SDI_CMD_NOP  = 4'b0111
  } sdi_cmd_e;

  typedef enum logic [2:0] {
    SDI_ST_POWERUP  = 3'b000,
    SDI_ST_WAIT_PRE = 3'b001,
    SDI_ST_PRE_WAIT = 3'b010,
    SDI_ST_SETUP    = 3'b011,
    SDI_ST_READY    = 3'b100
  } sdi_state_e;

  typedef enum logic [1:0] {
    SDI_ORG_X4  = 2'b00,
    SDI_ORG_X8  = 2'b01,
    SDI_ORG_X16 = 2'b10
  } sdi_org_e;

  localparam logic [COL_W-1:0] PAGE_MASK_X4 = 11'h7FF;
  localparam logic [COL_W-1:0] PAGE_MASK_X8 = 11'h3FF;
  localparam logic [COL_W-1:0] PAGE_MASK_X16 = 11'h1FF;

  // burst length code in the low mode bits; 7 selects a whole page
  localparam logic [2:0] BL_FULL_PAGE = 3'h7;

  // register map, byte addresses
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_MODE = 12'h008;
  localparam logic [11:0] REG_ACCESS = 12'h00C;
  localparam logic [11:0] REG_ERR = 12'h010;

  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam int ERR_EARLY = 0;
  localparam int ERR_IN_WAIT = 1;
  localparam int ERR_NOT_READY = 2;
  localparam int ERR_BANK_CLOSED = 3;
  localparam int ERR_MLOAD_BANK = 4;
  localparam int ERR_W = 5;

endpackage

// file: core/sdi_bank.sv
/*
  One bank's row state: whether a row is open and which one.
  Assumes the command decoder gives one-cycle activate and precharge strobes.
*/
`timescale 1ns/1ps
module sdi_bank (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic activate,
  input wire logic precharge,
  input wire logic [sdi_pkg::ROW_W-1:0] row_in,
  output logic open_q,
  output logic [sdi_pkg::ROW_W-1:0] row_q
);
  import sdi_pkg::*;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      open_q <= 1'b0;
    end else if (precharge) begin
      open_q <= 1'b0;
    end else if (activate) begin
      open_q <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      row_q <= '0;
    end else if (activate) begin
      row_q <= row_in;
    end
  end
endmodule

// file: core/sdi_burst.sv
/*
  Burst column sequencer: steps from the start column for the programmed
  length, wrapping inside the aligned block (or the page for full-page bursts).
  Assumes start and stop are one-cycle strobes from the command decoder.
*/
`timescale 1ns/1ps
module sdi_burst (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic stop,
  input wire logic [sdi_pkg::COL_W-1:0] start_col,
  input wire logic [2:0] len_code,
  input wire logic [sdi_pkg::COL_W-1:0] page_mask,
  output logic active_q,
  output logic [sdi_pkg::COL_W-1:0] col_q
);
  import sdi_pkg::*;

  logic [COL_W-1:0] wrap_mask_d;
  logic [COL_W-1:0] wrap_mask_q;
  logic [COL_W-1:0] left_q;
  logic [COL_W-1:0] next_col;

  // reserved length codes fall back to single beats
  always_comb begin
    case (len_code)
      3'h1: wrap_mask_d = 11'h001;
      3'h2: wrap_mask_d = 11'h003;
      3'h3: wrap_mask_d = 11'h007;
      BL_FULL_PAGE: wrap_mask_d = page_mask;
      default: wrap_mask_d = 11'h000;
    endcase
  end

  assign next_col = (col_q & ~wrap_mask_q) | ((col_q + 11'h001) & wrap_mask_q);

  // a full page keeps wrapping until stop, a new start or a change of page mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_q <= 1'b0;
      col_q <= '0;
      left_q <= '0;
      wrap_mask_q <= '0;
    end else if (start) begin
      active_q <= 1'b1;
      col_q <= start_col & page_mask;
      left_q <= wrap_mask_d;
      wrap_mask_q <= wrap_mask_d;
    end else if (stop) begin
      active_q <= 1'b0;
    end else if (active_q) begin
      col_q <= next_col;
      if (left_q == 11'h000) begin
        active_q <= (wrap_mask_q == page_mask) && (len_code == BL_FULL_PAGE);
      end else begin
        left_q <= left_q - 11'h001;
      end
    end
  end
endmodule

// file: core/sdi_core.sv
/*
  Device-side start-up tracking and address decoding for a quad-bank SDRAM,
  with an APB register view of its state.
  Assumes the memory controller drives the command pins from logic on pclk.
*/
// Register access over APB and the address map were left to the implementer.
// Overview of operation
// [RL1] sample all pins on pclk rising edge
// [RL2] four banks, 8192 rows, organization-sized pages
// [RL3] read or write needs an open row
// [RL4] activate: bank selects bank, A0-A12 row
// [RL5] column bits depend on x4, x8, x16
// [RL6] every access is a programmed burst
// [RL7] no real command before start-up wait
// [RL8] inhibit or nop seen during start-up wait
// [RL9] clock enable low at power-up, later high
// [RL10] precharge all, wait, banks go idle
// [RL11] two or more refreshes, each waited out
// [RL12] extra refresh loops are allowed
// [RL13] mode must be loaded before operation
// [RL14] mode load needs both bank bits zero
// [RL15] mode value held until reloaded
// [RL16] data outputs off from mode load on
// [RL17] only nop during mode-load wait
// [RL18] refreshes may follow the mode load
// [RL19] deselect ignores commands, bursts continue
// [RL20] address bit ten high precharges all banks
// [RL21] commands decoded from strobe truth table
`timescale 1ns/1ps
module sdi_core #(
  parameter int STARTUP_CYC = sdi_pkg::STARTUP_WAIT_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic bank_select_bit0,
  input wire logic bank_select_bit1,
  input wire logic [sdi_pkg::ROW_W-1:0] addr,
  input wire logic dqm,
  output logic [15:0] dq_o,
  output logic dq_oe,
  output logic init_done
);
  import sdi_pkg::*;

  // pin sampling
  logic cke_q;
  logic [3:0] cmd_q;
  logic [1:0] ba_q;
  logic [ROW_W-1:0] addr_q;
  logic dqm_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cke_q <= 1'b0;
      cmd_q <= 4'hF;
      ba_q <= 2'h0;
      addr_q <= '0;
      dqm_q <= 1'b1;
    end else begin
      cke_q <= cke; // RL1
      cmd_q <= {cs_n, ras_n, cas_n, we_n}; // RL1
      ba_q <= {bank_select_bit1, bank_select_bit0}; // RL1
      addr_q <= addr; // RL1
      dqm_q <= dqm;
    end
  end

  // command decode; low clock enable or high chip select decodes as a nop
  logic cmd_live;
  logic is_nop;
  logic is_act;
  logic is_rd;
  logic is_wr;
  logic is_pre;
  logic is_aref;
  logic is_mload;
  logic is_bst;
  logic auto_precharge_flag_bit;

  assign cmd_live = cke_q && !cmd_q[3]; // RL19 RL9
  assign is_nop = !cmd_live || (cmd_q == SDI_CMD_NOP); // RL21
  assign is_act = cmd_live && (cmd_q == SDI_CMD_ACT); // RL21
  assign is_rd = cmd_live && (cmd_q == SDI_CMD_RD);
  assign is_wr = cmd_live && (cmd_q == SDI_CMD_WR);
  assign is_pre = cmd_live && (cmd_q == SDI_CMD_PRE); // RL21
  assign is_aref = cmd_live && (cmd_q == SDI_CMD_AREF); // RL21
  assign is_mload = cmd_live && (cmd_q == SDI_CMD_MLOAD); // RL21
  assign is_bst = cmd_live && (cmd_q == SDI_CMD_BST);
  assign auto_precharge_flag_bit = addr_q[10];

  // software view of organization
  logic [1:0] org_q;
  logic [COL_W-1:0] page_mask;
  logic [COL_W-1:0] col_addr;

  always_comb begin
    if (org_q == SDI_ORG_X4) begin
      page_mask = PAGE_MASK_X4; // RL2
      col_addr = {addr_q[11], addr_q[9:0]}; // RL5
    end else if (org_q == SDI_ORG_X8) begin
      page_mask = PAGE_MASK_X8; // RL2
      col_addr = {1'b0, addr_q[9:0]}; // RL5
    end else begin
      page_mask = PAGE_MASK_X16; // RL2
      col_addr = {2'b00, addr_q[8:0]}; // RL5
    end
  end

  // start-up tracking
  sdi_state_e state_q;
  logic [31:0] start_cnt_q;
  logic nop_seen_q;
  logic [7:0] wait_cnt_q;
  logic [2:0] ref_cnt_q;
  logic mode_valid_q;
  logic [ROW_W-1:0] mode_q;
  logic startup_met;
  logic waiting;
  logic mload_ok;

  assign startup_met = (start_cnt_q >= 32'(STARTUP_CYC)) && nop_seen_q; // RL7 RL8
  assign waiting = (wait_cnt_q != 8'h00);
  assign mload_ok = is_mload && (ba_q == 2'b00) && !waiting; // RL14 RL17

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_cnt_q <= '0;
    end else if (start_cnt_q < 32'(STARTUP_CYC)) begin
      start_cnt_q <= start_cnt_q + 32'h1; // RL7
    end
  end

  // a nop counts anywhere in the power-up state, from reset until the wait is met
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nop_seen_q <= 1'b0;
    end else if (state_q == SDI_ST_POWERUP && is_nop && cmd_q[3:0] != 4'h0) begin
      nop_seen_q <= 1'b1; // RL8
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_cnt_q <= 8'h00;
    end else if (is_pre && !waiting) begin
      wait_cnt_q <= 8'(PRECHARGE_PERIOD_CYC); // RL10
    end else if (is_aref && !waiting) begin
      wait_cnt_q <= 8'(REFRESH_CYCLE_PERIOD_CYC); // RL11
    end else if (mload_ok) begin
      wait_cnt_q <= 8'(MODE_LOAD_WAIT_CYC); // RL17
    end else if (waiting) begin
      wait_cnt_q <= wait_cnt_q - 8'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= SDI_ST_POWERUP;
    end else begin
      case (state_q)
        SDI_ST_POWERUP: begin
          if (startup_met) begin
            state_q <= SDI_ST_WAIT_PRE;
          end
        end
        SDI_ST_WAIT_PRE: begin
          if (is_pre && auto_precharge_flag_bit) begin
            state_q <= SDI_ST_PRE_WAIT; // RL10 RL20
          end
        end
        SDI_ST_PRE_WAIT: begin
          if (!waiting) begin
            state_q <= SDI_ST_SETUP; // RL10
          end
        end
        SDI_ST_SETUP: begin
          // refreshes and mode load in either order
          if (!waiting && mode_valid_q && ref_cnt_q >= 3'(MIN_REFRESHES)) begin
            state_q <= SDI_ST_READY; // RL11 RL13 RL18
          end
        end
        SDI_ST_READY: begin
          state_q <= SDI_ST_READY;
        end
        default: begin
          state_q <= SDI_ST_POWERUP;
        end
      endcase
    end
  end

  // saturates; further loops are legal
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_cnt_q <= 3'h0;
    end else if (is_aref && !waiting && state_q == SDI_ST_SETUP && ref_cnt_q != 3'h7) begin
      ref_cnt_q <= ref_cnt_q + 3'h1; // RL11 RL12
    end
  end

  // mode value only changes on a good load
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_valid_q <= 1'b0;
      mode_q <= '0;
    end else if (mload_ok && (state_q == SDI_ST_SETUP || state_q == SDI_ST_READY)) begin
      mode_valid_q <= 1'b1; // RL13
      mode_q <= addr_q; // RL15
    end
  end

  // banks
  logic [3:0] bank_open;
  logic [ROW_W-1:0] bank_row [4];
  logic ready;

  assign ready = (state_q == SDI_ST_READY);

  for (genvar b = 0; b < 4; b++) begin : g_bank
    logic act_b;
    logic pre_b;
    assign act_b = ready && is_act && (ba_q == 2'(b)); // RL4
    assign pre_b = is_pre && !waiting && (auto_precharge_flag_bit || ba_q == 2'(b)); // RL20
    sdi_bank u_bank (
      .pclk(pclk),
      .presetn(presetn),
      .activate(act_b),
      .precharge(pre_b),
      .row_in(addr_q),
      .open_q(bank_open[b]),
      .row_q(bank_row[b])
    );
  end

  // bursts
  logic access_ok;
  logic burst_active;
  logic [COL_W-1:0] burst_col;
  logic rd_burst_q;
  logic [1:0] burst_bank_q;
  logic [1:0] dqm_pipe_q;

  assign access_ok = ready && (is_rd || is_wr) && bank_open[ba_q]; // RL3

  // read and write restart a burst, terminate, precharge and mode load end it; activate, refresh and deselect leave it running
  sdi_burst u_burst (
    .pclk(pclk),
    .presetn(presetn),
    .start(access_ok), // RL6
    .stop(is_bst || is_pre || is_mload),
    .start_col(col_addr),
    .len_code(mode_q[2:0]), // RL6
    .page_mask(page_mask),
    .active_q(burst_active),
    .col_q(burst_col)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_burst_q <= 1'b0;
      burst_bank_q <= 2'h0;
    end else if (access_ok) begin
      rd_burst_q <= is_rd;
      burst_bank_q <= ba_q;
    end
  end

  // output mask acts three clocks after it is sampled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dqm_pipe_q <= 2'b11;
    end else begin
      dqm_pipe_q <= {dqm_pipe_q[0], dqm_q}; // RL19
    end
  end

  // no array behind it: read beats return their own bank and column
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dq_o <= 16'h0000;
      dq_oe <= 1'b0;
    end else begin
      dq_o <= {3'h0, burst_bank_q, burst_col};
      dq_oe <= burst_active && rd_burst_q && !dqm_pipe_q[1] && !is_mload; // RL16
    end
  end

  // last access seen
  logic [26:0] access_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      access_q <= '0;
    end else if (access_ok) begin
      access_q <= {is_wr, ba_q, bank_row[ba_q], col_addr}; // RL4 RL5
    end
  end

  // sticky protocol errors
  logic [ERR_W-1:0] err_q;
  logic [ERR_W-1:0] err_set;
  logic [ERR_W-1:0] err_clr;
  logic apb_wr;
  logic apb_setup;

  assign apb_wr = psel && penable && pwrite;
  assign apb_setup = psel && !penable;

  always_comb begin
    err_set = '0;
    err_set[ERR_EARLY] = !is_nop && state_q == SDI_ST_POWERUP; // RL7
    err_set[ERR_IN_WAIT] = !is_nop && waiting; // RL10 RL11 RL17
    err_set[ERR_NOT_READY] = (is_act || is_rd || is_wr) && !ready; // RL13
    err_set[ERR_BANK_CLOSED] = ready && (is_rd || is_wr) && !bank_open[ba_q]; // RL3
    err_set[ERR_MLOAD_BANK] = is_mload && ba_q != 2'b00; // RL14
    err_clr = (apb_wr && paddr == REG_ERR) ? pwdata[ERR_W-1:0] : '0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_q <= '0;
    end else begin
      err_q <= (err_q & ~err_clr) | err_set;
    end
  end

  // APB slave: zero wait states, read data captured in the setup cycle
  logic mapped;

  always_comb begin
    if (paddr == REG_CTRL) begin
      mapped = 1'b1;
    end else if (paddr == REG_STATUS) begin
      mapped = 1'b1;
    end else if (paddr == REG_MODE) begin
      mapped = 1'b1;
    end else if (paddr == REG_ACCESS) begin
      mapped = 1'b1;
    end else if (paddr == REG_ERR) begin
      mapped = 1'b1;
    end else begin
      mapped = 1'b0;
    end
  end

  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      org_q <= CTRL_RESET;
    end else if (apb_wr && paddr == REG_CTRL && pwdata[1:0] != 2'b11) begin
      org_q <= pwdata[1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (apb_setup && !pwrite) begin
      if (paddr == REG_CTRL) begin
        prdata <= {30'h0, org_q};
      end else if (paddr == REG_STATUS) begin
        prdata <= {19'h0, dq_oe, burst_active, bank_open, ref_cnt_q, mode_valid_q, state_q};
      end else if (paddr == REG_MODE) begin
        prdata <= {19'h0, mode_q};
      end else if (paddr == REG_ACCESS) begin
        prdata <= {5'h0, access_q};
      end else if (paddr == REG_ERR) begin
        prdata <= {27'h0, err_q};
      end else begin
        prdata <= 32'h0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_done <= 1'b0;
    end else begin
      init_done <= ready;
    end
  end
endmodule

// file: dv/sdi_core_chk.sv
/*
  Concurrent checks on the sdi_core ports: start-up order, read beats, bank field.
  Assumes the pins are driven from logic on pclk and the bench reads bursts of four.
*/
`timescale 1ns/1ps
module sdi_core_chk #(
  parameter int STARTUP_CYC = 20
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic bank_select_bit0,
  input wire logic bank_select_bit1,
  input wire logic [sdi_pkg::ROW_W-1:0] addr,
  input wire logic [15:0] dq_o,
  input wire logic dq_oe,
  input wire logic init_done
);
  import sdi_pkg::*;
  // pin decode as the device must see it; cs_n high or cke low masks all
  wire logic on_w = cke && !cs_n;
  wire logic rd_w = on_w && ras_n && !cas_n && we_n;
  wire logic act_w = on_w && !ras_n && cas_n && we_n;
  wire logic pre_w = on_w && !ras_n && cas_n && !we_n;
  wire logic aref_w = on_w && !ras_n && !cas_n && we_n;
  wire logic ml_w = on_w && !ras_n && !cas_n && !we_n && !bank_select_bit0 && !bank_select_bit1;
  wire logic [1:0] bk = {bank_select_bit1, bank_select_bit0};
  int cyc_q;
  logic [1:0] aref_q;
  logic ml_q;
  logic [3:0] open_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cyc_q <= 0;
    else if (cyc_q < STARTUP_CYC) cyc_q <= cyc_q + 1;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aref_q <= 2'h0;
      ml_q <= 1'b0;
    end else begin
      if (aref_w && aref_q != 2'h3) aref_q <= aref_q + 2'h1;
      if (ml_w) ml_q <= 1'b1;
    end
  end
  // open banks as seen on the pins once ready; only legal traffic is expected then
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) open_q <= 4'h0;
    else if (init_done && act_w) open_q[bk] <= 1'b1;
    else if (init_done && pre_w) open_q <= addr[10] ? 4'h0 : open_q & ~(4'h1 << bk);
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_good_rd;
    init_done && rd_w && open_q[bk];
  endsequence
  sequence s_beat;
    ##[1:3] dq_oe;
  endsequence
  a_no_early: assert property (cyc_q < STARTUP_CYC |-> !init_done) else $error("ready too soon");
  a_init_needs: assert property ($rose(init_done) |-> aref_q >= 2'h2 && ml_q) else $error("ready too soon");
  a_done_holds: assert property (init_done |=> init_done) else $error("ready dropped");
  a_oe_before: assert property (!init_done |-> !dq_oe) else $error("dq driven before ready");
  a_oe_cause: assert property ($rose(dq_oe) |-> $past(rd_w) || $past(rd_w, 2) || $past(rd_w, 3))
    else $error("dq driven without read");
  a_read_beat: assert property (s_good_rd |-> s_beat) else $error("read gave no beat");
  a_beat_field: assert property (dq_oe |-> dq_o[15:13] == 3'h0) else $error("beat high bits set");
  a_beat_bank: assert property ($rose(dq_oe) |-> dq_o[12:11] == $past(bk, 3)) else $error("beat bank wrong");
endmodule

bind sdi_core sdi_core_chk #(.STARTUP_CYC(STARTUP_CYC)) chk_u (.*);

// file: dv/sdi_ctl_model.sv
/*
  Memory controller model driving the command pins of sdi_core.
  Assumes the bench calls its tasks from one process, one at a time.
*/
`timescale 1ns/1ps
module sdi_ctl_model (
  input wire logic pclk,
  output logic cke,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic bank_select_bit0,
  output logic bank_select_bit1,
  output logic [sdi_pkg::ROW_W-1:0] addr,
  output logic dqm
);
  import sdi_pkg::*;
  initial begin
    cke = 1'b0;
    {cs_n, ras_n, cas_n, we_n} = 4'hF;
    {bank_select_bit1, bank_select_bit0} = 2'h0;
    addr = '0;
    dqm = 1'b0;
  end
  // idle nops toggle address and bank, so decoding them would show
  task automatic nops(input int n);
    repeat (n) begin
      @(posedge pclk);
      {cs_n, ras_n, cas_n, we_n} <= SDI_CMD_NOP;
      addr <= ~addr;
      bank_select_bit0 <= ~bank_select_bit0;
    end
  endtask
  task automatic cmd(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a);
    @(posedge pclk);
    {cs_n, ras_n, cas_n, we_n} <= c;
    {bank_select_bit1, bank_select_bit0} <= b;
    addr <= a;
    nops(1);
  endtask
  task automatic power_up(input int n);
    repeat (3) @(posedge pclk);
    cke <= 1'b1;
    nops(n);
  endtask
endmodule

// file: dv/testbench.sv
/*
  Self-checking bench for sdi_core: start-up, errors, random reads per organization.
  Assumes the controller model drives the pins and this module drives APB.
*/
`timescale 1ns/1ps
module testbench;
  import sdi_pkg::*;
  localparam int SU = 20;
  logic pclk, presetn, psel, penable, pwrite, pslverr, pready, dqm, dq_oe, init_done, last_err;
  logic cke, cs_n, ras_n, cas_n, we_n, bank_select_bit0, bank_select_bit1;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic [ROW_W-1:0] addr, r, a;
  logic [15:0] dq_o;
  logic [1:0] b;
  logic [10:0] c;
  int num_errors, checked;
  sdi_core #(.STARTUP_CYC(SU)) dut_u (.*);
  sdi_ctl_model ctl_u (.*);
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rv = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [10:0] col_of(input logic [1:0] org, input logic [12:0] x);
    case (org)
      2'h0: col_of = {x[11], x[9:0]};
      2'h1: col_of = {1'b0, x[9:0]};
      default: col_of = {2'h0, x[8:0]};
    endcase
  endfunction
  task automatic end_of_test();
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #50000;
    num_errors++;
    end_of_test();
  end
  initial begin
    {psel, penable, pwrite, presetn} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    num_errors = 0;
    checked = 0;
    void'($urandom(32'hBF18));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, REG_CTRL, 0);
    check(rv, 32'h0);
    ctl_u.power_up(5);
    ctl_u.cmd(SDI_CMD_ACT, 2'h0, 13'h0000);
    ctl_u.nops(2 * SU);
    ctl_u.cmd(SDI_CMD_PRE, 2'h0, 13'h0400);
    ctl_u.nops(PRECHARGE_PERIOD_CYC + 2);
    apb(0, REG_STATUS, 0);
    check(rv[2:0], 32'h3);
    // second refresh lands inside the first one's wait
    ctl_u.cmd(SDI_CMD_AREF, 2'h0, 13'h0000);
    ctl_u.cmd(SDI_CMD_AREF, 2'h0, 13'h0000);
    ctl_u.nops(REFRESH_CYCLE_PERIOD_CYC + 2);
    ctl_u.cmd(4'h0, 2'h1, 13'h0023);
    ctl_u.nops(3);
    ctl_u.cmd(4'h0, 2'h0, 13'h0022);
    ctl_u.nops(MODE_LOAD_WAIT_CYC + 2);
    apb(0, REG_STATUS, 0);
    check(rv[6:0], 32'h1B);
    check(init_done, 32'h0);
    repeat (2) begin
      ctl_u.cmd(SDI_CMD_AREF, 2'h0, 13'h0000);
      ctl_u.nops(REFRESH_CYCLE_PERIOD_CYC + 2);
    end
    apb(0, REG_STATUS, 0);
    check(rv, 32'h2C);
    check(init_done, 32'h1);
    apb(0, REG_MODE, 0);
    check(rv, 32'h22);
    apb(0, REG_ERR, 0);
    check(rv & 32'h13, 32'h13);
    apb(1, REG_ERR, 32'h1F);
    apb(0, REG_ERR, 0);
    check(rv, 32'h0);
    apb(0, 12'h014, 0);
    check({rv[30:0], last_err}, 32'h1);
    ctl_u.cmd(4'hB, 2'h1, 13'h0000);
    ctl_u.nops(2);
    apb(0, REG_STATUS, 0);
    check(rv[10:7], 32'h0);
    for (int org = 0; org < 3; org++) begin
      apb(1, REG_CTRL, org);
      repeat (2) begin
        b = $urandom;
        r = $urandom;
        a = $urandom;
        a[10] = 1'b0;
        c = col_of(org[1:0], a);
        ctl_u.cmd(SDI_CMD_ACT, b, r);
        ctl_u.cmd(SDI_CMD_RD, b, a);
        for (int i = 0; i < 8 && dq_oe !== 1'b1; i++) @(negedge pclk);
        for (int i = 0; i < 4; i++) begin
          check(dq_o, {3'h0, b, c[10:2], c[1:0] + i[1:0]});
          @(negedge pclk);
        end
        check(dq_oe, 32'h0);
        apb(0, REG_ACCESS, 0);
        check(rv, {6'h0, b, r, c});
        apb(0, REG_STATUS, 0);
        check(rv[10:7], 4'h1 << b);
        ctl_u.cmd(SDI_CMD_PRE, b, 13'h0000);
        ctl_u.nops(PRECHARGE_PERIOD_CYC + 2);
      end
    end
    ctl_u.cmd(SDI_CMD_ACT, 2'h2, r);
    ctl_u.cmd(SDI_CMD_ACT, 2'h3, r);
    ctl_u.cmd(SDI_CMD_PRE, 2'h1, 13'h0400);
    ctl_u.nops(PRECHARGE_PERIOD_CYC + 2);
    apb(0, REG_STATUS, 0);
    check(rv[10:7], 32'h0);
    ctl_u.cmd(SDI_CMD_RD, 2'h2, 13'h0005);
    ctl_u.nops(5);
    check(dq_oe, 32'h0);
    apb(0, REG_ERR, 0);
    check(rv[3], 32'h1);
    apb(1, REG_CTRL, 3);
    apb(0, REG_CTRL, 0);
    check(rv, 32'h2);
    end_of_test();
  end
endmodule
